//--- shared/fcs_pkg.sv
// Package for the flash command sequencer: constants, types and behaviour notes
// Notes on behaviour
// - Command write clears ready flag at once
// - Completion sets ready, interrupt if enabled
// - Quick reads never raise completion interrupt
// - Flash reads stall while command busy
// - Command starts on first idle bus cycle
// - Wrong key or code sets program error
// - Status read clears both error flags
// - Command while busy sets program error
// - Locked or boot page write sets lock error
// - Boot area protected by locks and fuses
// - Page buffer aliased across flash space
// - Page number updated by buffer writes
// - Non-secure master on secure page: lock error
// - Erase-all sets array and fuses to ones
// - Erase-all clears volatile before security bit
// - Erase-all refused when locked or boot protected
// - Sixteen equal lock regions, one bit each
// - Lock/unlock command acts on page's region
// - Lock bits are low fuses, one unlocked
// - Flash write updates buffer and page number
// - Buffer writes only clear bits to zero
package fcs_pkg;
    localparam logic [7:0] FCS_KEY = 8'ha5;
    localparam logic [5:0] FCS_CMD_WP = 6'h01;
    localparam logic [5:0] FCS_CMD_EP = 6'h02;
    localparam logic [5:0] FCS_CMD_CPB = 6'h03;
    localparam logic [5:0] FCS_CMD_LOCK = 6'h04;
    localparam logic [5:0] FCS_CMD_UNLOCK = 6'h05;
    localparam logic [5:0] FCS_CMD_EA = 6'h06;
    localparam logic [5:0] FCS_CMD_QPR = 6'h0c;
    localparam logic [5:0] FCS_CMD_QUICK_USER_PAGE_READ = 6'h0f;
    localparam logic [11:0] FCS_OFF_CTRL = 12'h000;
    localparam logic [11:0] FCS_OFF_CMD = 12'h004;
    localparam logic [11:0] FCS_OFF_STAT = 12'h008;
    localparam logic [11:0] FCS_OFF_FUSE = 12'h00c;
    localparam logic [11:0] FCS_OFF_SECURE = 12'h010;
    localparam int FCS_CMD_KEY_LSB = 24;
    localparam int FCS_CMD_PAGE_LSB = 8;
    localparam int FCS_CTRL_RDY_IE = 0;
    localparam int FCS_CTRL_LOCK_ERROR_FLAG_IE = 2;
    localparam int FCS_STAT_RDY = 0;
    localparam int FCS_STAT_LOCK_ERROR_FLAG = 2;
    localparam int FCS_STAT_PROGRAM_ERROR_FLAG = 3;
    localparam int FCS_STAT_QPRR = 5;
    localparam int FCS_STAT_SEC = 4;
    localparam int FCS_OP_CYCLES = 16;
    localparam logic [31:0] FCS_FUSE_RESET = 32'hffff_ffff;
    localparam logic [1:0] FCS_RESP_OKAY = 2'b00;
    localparam logic [1:0] FCS_RESP_SLVERR = 2'b10;
    typedef enum logic [3:0] {
        FCS_IDLE = 4'b0001,
        FCS_WAIT = 4'b0010,
        FCS_RUN = 4'b0100,
        FCS_DONE = 4'b1000
    } fcs_state_t;
    typedef struct packed {
        logic rdy;
        logic program_error_flag;
        logic lock_error_flag;
        logic qprr;
        logic sec;
    } fcs_stat_t;
endpackage : fcs_pkg

//--- core/fcs_sequencer.sv
// Flash command sequencer with AXI4-Lite registers and flash word port
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int PAGES = 256,
    parameter int WORDS = 32,
    parameter int OP_CYCLES = FCS_OP_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic [15:0] f_addr,
    input wire logic f_wr,
    input wire logic f_rd,
    input wire logic f_secure,
    input wire logic [31:0] f_wdata,
    output logic f_stall,
    output logic [31:0] f_rdata,
    output logic f_rvalid,
    output logic irq,
    output logic wipe_volatile
);
    localparam int PW = $clog2(PAGES);
    localparam int WW = $clog2(WORDS);
    localparam int RPW = PW - 4;
    localparam int CW = $clog2(OP_CYCLES + 1);
    initial
    begin
        if (PAGES < 256 || WORDS < 2 || (PAGES % 16) != 0 || PW > 16 || PW + WW > 16)
        begin
            $error("fcs_sequencer: unsupported PAGES or WORDS");
        end
    end
    logic [31:0] mem [PAGES*WORDS];
    logic [31:0] user [WORDS];
    logic [31:0] pbuf [WORDS];
    logic [31:0] fuse;
    logic [31:0] ctrl;
    logic [31:0] secure_map;
    logic [PW-1:0] page;
    logic [5:0] cmd;
    fcs_stat_t st;
    fcs_state_t state;
    logic [CW-1:0] cnt;
    logic [11:0] awa;
    logic [31:0] wd;
    logic aw_h, w_h;
    logic [PW-1:0] next_page;
    logic [5:0] next_cmd;
    fcs_stat_t next_st;
    fcs_state_t next_state;
    logic [CW-1:0] next_cnt;
    logic [2:0] boot;
    logic [PW-1:0] boot_pages;
    logic busy, cmd_wr, key_ok, code_ok, stat_rd, page_locked, page_secure, done_evt;
    logic [PW-1:0] cmd_page;
    logic [31:0] and_all;
    assign boot = fuse[19:17];
    // Boot pages 0 .. 2^(7-boot)-1 protected unless boot is 7
    assign boot_pages = (boot == 3'd7) ? '0 : PW'(2 ** (7 - int'(boot)) - 1);
    assign busy = (state != FCS_IDLE);
    assign cmd_wr = aw_h && w_h && !s_bvalid && (awa == FCS_OFF_CMD);
    assign cmd_page = wd[FCS_CMD_PAGE_LSB +: PW];
    assign key_ok = (wd[FCS_CMD_KEY_LSB +: 8] == FCS_KEY);
    assign code_ok = (wd[5:0] == FCS_CMD_WP) || (wd[5:0] == FCS_CMD_EP) ||
        (wd[5:0] == FCS_CMD_CPB) || (wd[5:0] == FCS_CMD_LOCK) ||
        (wd[5:0] == FCS_CMD_UNLOCK) || (wd[5:0] == FCS_CMD_EA) ||
        (wd[5:0] == FCS_CMD_QPR) || (wd[5:0] == FCS_CMD_QUICK_USER_PAGE_READ);
    assign stat_rd = s_arvalid && !s_rvalid && (s_araddr == FCS_OFF_STAT);
    // Region is page's top four bits; fuse zero means locked
    assign page_locked = !fuse[page[PW-1 -: 4]] || (page <= boot_pages && boot != 3'd7);
    assign page_secure = secure_map[page[PW-1 -: 4]] && !f_secure;
    assign done_evt = (state == FCS_DONE);
    always_comb
    begin
        and_all = '1;
        for (int i = 0; i < WORDS; i++)
        begin
            and_all = and_all & ((cmd == FCS_CMD_QUICK_USER_PAGE_READ) ? user[i] : mem[{page, WW'(i)}]);
        end
    end
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_cmd = cmd;
        next_page = page;
        next_st = st;
        if (stat_rd)
        begin
            next_st.program_error_flag = 1'b0;
            next_st.lock_error_flag = 1'b0;
        end
        if (f_wr && !busy)
        begin
            next_page = f_addr[WW +: PW];
        end
        case (state)
            FCS_IDLE:
            begin
                if (cmd_wr)
                begin
                    next_page = cmd_page;
                    if (key_ok && code_ok)
                    begin
                        next_cmd = wd[5:0];
                        next_st.rdy = 1'b0;
                        next_state = FCS_WAIT;
                    end
                    else
                    begin
                        next_st.program_error_flag = 1'b1;
                    end
                end
            end
            FCS_WAIT:
            begin
                if (cmd_wr)
                begin
                    next_st.program_error_flag = 1'b1;
                end
                if (!f_rd && !f_wr)
                begin
                    next_state = FCS_RUN;
                    next_cnt = CW'(OP_CYCLES);
                    if (cmd == FCS_CMD_EA && (fuse[15:0] != 16'hffff || boot != 3'd7))
                    begin
                        next_st.lock_error_flag = 1'b1;
                        next_state = FCS_DONE;
                    end
                    if ((cmd == FCS_CMD_WP || cmd == FCS_CMD_EP) && (page_locked || page_secure))
                    begin
                        next_st.lock_error_flag = 1'b1;
                        next_state = FCS_DONE;
                    end
                end
            end
            FCS_RUN:
            begin
                if (cmd_wr)
                begin
                    next_st.program_error_flag = 1'b1;
                end
                next_cnt = cnt - 1'b1;
                if (cnt == 1)
                begin
                    next_state = FCS_DONE;
                    if (cmd == FCS_CMD_QPR || cmd == FCS_CMD_QUICK_USER_PAGE_READ)
                    begin
                        next_st.qprr = &and_all;
                    end
                end
            end
            FCS_DONE:
            begin
                if (cmd_wr)
                begin
                    next_st.program_error_flag = 1'b1;
                end
                next_st.rdy = 1'b1;
                next_state = FCS_IDLE;
            end
            default:
            begin
                next_state = FCS_IDLE;
            end
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= FCS_IDLE;
            cnt <= '0;
            cmd <= '0;
            page <= '0;
            st <= '{rdy: 1'b1, program_error_flag: 1'b0, lock_error_flag: 1'b0, qprr: 1'b0, sec: 1'b0};
            fuse <= FCS_FUSE_RESET;
            wipe_volatile <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            cmd <= next_cmd;
            page <= next_page;
            st <= next_st;
            wipe_volatile <= (state == FCS_RUN && cmd == FCS_CMD_EA && cnt == 2);
            irq <= (done_evt && ctrl[FCS_CTRL_RDY_IE] && cmd != FCS_CMD_QPR &&
                cmd != FCS_CMD_QUICK_USER_PAGE_READ) ||
                (done_evt && st.lock_error_flag && ctrl[FCS_CTRL_LOCK_ERROR_FLAG_IE] && cmd == FCS_CMD_EA);
            if (state == FCS_RUN && cnt == 1)
            begin
                if (cmd == FCS_CMD_LOCK)
                begin
                    fuse[page[PW-1 -: 4]] <= 1'b0;
                end
                if (cmd == FCS_CMD_UNLOCK)
                begin
                    fuse[page[PW-1 -: 4]] <= 1'b1;
                end
                if (cmd == FCS_CMD_EA)
                begin
                    fuse <= FCS_FUSE_RESET;
                end
            end
            if (state == FCS_DONE && cmd == FCS_CMD_EA && !st.lock_error_flag)
            begin
                st.sec <= 1'b0;
            end
        end
    end
    // Flash array and page buffer storage
    always_ff @(posedge aclk)
    begin
        if (f_wr && !busy)
        begin
            pbuf[f_addr[WW-1:0]] <= pbuf[f_addr[WW-1:0]] & f_wdata;
        end
        if (state == FCS_RUN && cnt == 1)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                if (cmd == FCS_CMD_CPB)
                begin
                    pbuf[i] <= '1;
                end
                if (cmd == FCS_CMD_WP)
                begin
                    mem[{page, WW'(i)}] <= mem[{page, WW'(i)}] & pbuf[i];
                end
                if (cmd == FCS_CMD_EP)
                begin
                    mem[{page, WW'(i)}] <= '1;
                end
            end
            if (cmd == FCS_CMD_EA)
            begin
                for (int j = 0; j < PAGES * WORDS; j++)
                begin
                    mem[j] <= '1;
                end
            end
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            f_stall <= 1'b0;
            f_rvalid <= 1'b0;
            f_rdata <= '0;
        end
        else
        begin
            f_stall <= next_state != FCS_IDLE;
            f_rvalid <= f_rd && !busy;
            f_rdata <= mem[f_addr[PW+WW-1:0]];
        end
    end
    // AXI4-Lite slave
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            awa <= '0;
            wd <= '0;
            s_bvalid <= 1'b0;
            s_bresp <= FCS_RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= FCS_RESP_OKAY;
            ctrl <= '0;
            secure_map <= '0;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_h <= 1'b1;
                awa <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_h <= 1'b1;
                wd <= s_wdata;
            end
            if (aw_h && w_h && !s_bvalid)
            begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= FCS_RESP_OKAY;
                if (awa == FCS_OFF_CTRL)
                begin
                    ctrl <= wd & 32'h0000_0005;
                end
                else if (awa == FCS_OFF_SECURE)
                begin
                    secure_map <= {16'h0000, wd[15:0]};
                end
                else if (awa != FCS_OFF_CMD)
                begin
                    s_bresp <= FCS_RESP_SLVERR;
                end
            end
            if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
            end
            if (s_arvalid && !s_rvalid)
            begin
                s_rvalid <= 1'b1;
                s_rresp <= FCS_RESP_OKAY;
                case (s_araddr)
                    FCS_OFF_CTRL: s_rdata <= ctrl;
                    FCS_OFF_CMD: s_rdata <= {26'h000_0000, cmd} | (32'(page) << FCS_CMD_PAGE_LSB);
                    FCS_OFF_STAT: s_rdata <= (32'(st.rdy) << FCS_STAT_RDY) |
                        (32'(st.lock_error_flag) << FCS_STAT_LOCK_ERROR_FLAG) | (32'(st.program_error_flag) << FCS_STAT_PROGRAM_ERROR_FLAG) |
                        (32'(st.sec) << FCS_STAT_SEC) | (32'(st.qprr) << FCS_STAT_QPRR);
                    FCS_OFF_FUSE: s_rdata <= fuse;
                    FCS_OFF_SECURE: s_rdata <= secure_map;
                    default:
                    begin
                        s_rdata <= '0;
                        s_rresp <= FCS_RESP_SLVERR;
                    end
                endcase
            end
            if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
            end
        end
    end
    always_comb
    begin
        s_awready = !aw_h && aresetn;
        s_wready = !w_h && aresetn;
        s_arready = !s_rvalid && aresetn;
    end
    initial
    begin
        for (int k = 0; k < WORDS; k++)
        begin
            user[k] = '1;
        end
    end
endmodule : fcs_sequencer
`default_nettype wire

//--- tb/fcs_flash_master.sv
// Flash port master model that backs off while the sequencer is busy
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_master (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic wr,
    input wire logic f_stall,
    input wire logic f_rvalid,
    output logic [15:0] f_addr,
    output logic f_wr,
    output logic f_rd,
    output logic f_secure,
    output logic [31:0] f_wdata,
    output logic got
);
    logic [1:0] st;
    assign f_addr = 16'h0500;
    assign f_secure = 1'b0;
    assign f_wdata = 32'h0000_fff0;
    // Aligned full-word buffer write, only while the sequencer is idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            f_wr <= 1'b0;
        else
            f_wr <= wr && !f_stall;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= 2'h0;
            f_rd <= 1'b0;
            got <= 1'b0;
        end
        else if (st == 2'h0 && start)
        begin
            f_rd <= 1'b1;
            got <= 1'b0;
            st <= 2'h1;
        end
        else if (st == 2'h1)
        begin
            f_rd <= 1'b0;
            st <= 2'h2;
        end
        else if (st == 2'h2 && f_rvalid)
        begin
            got <= 1'b1;
            st <= 2'h0;
        end
        else if (st == 2'h2 && !f_stall)
        begin
            f_rd <= 1'b1;
            st <= 2'h1;
        end
    end
endmodule : fcs_flash_master
`default_nettype wire

//--- tb/fcs_sequencer_assertions.sv
// Assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic f_rd,
    input wire logic f_stall,
    input wire logic f_rvalid,
    input wire logic irq,
    input wire logic wipe_volatile
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_busy_rd;
        f_rd && f_stall;
    endsequence
    sequence s_idle_rd;
        f_rd && !f_stall;
    endsequence
    a_busy_read_held: assert property (s_busy_rd |=> !f_rvalid)
        else $error("read answered while busy");
    a_idle_read_done: assert property (s_idle_rd |=> f_rvalid)
        else $error("idle read not answered");
    a_busy_ends: assert property ($rose(f_stall) |-> ##[1:60] !f_stall)
        else $error("command never finished");
    a_irq_one_pulse: assert property (irq |=> !irq)
        else $error("irq longer than one cycle");
    a_wipe_one_pulse: assert property (wipe_volatile |=> !wipe_volatile)
        else $error("wipe longer than one cycle");
    a_wipe_while_busy: assert property (wipe_volatile |-> f_stall)
        else $error("wipe outside erase-all");
    a_bresp_holds: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
endmodule : fcs_sequencer_assertions
bind fcs_sequencer fcs_sequencer_assertions u_chk (.*);
`default_nettype wire

//--- tb/fcs_sequencer_tb.sv
// Testbench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_tb;
    import fcs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
    logic s_rready = 1'b0, start = 1'b0, wr = 1'b0;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0] s_wstrb = 4'hf;
    logic [1:0] s_bresp, s_rresp;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, f_wr, f_rd, f_secure;
    logic f_stall, f_rvalid, irq, wipe_volatile, got;
    logic [31:0] s_rdata, f_rdata, f_wdata;
    logic [15:0] f_addr;
    int n_errors = 0, total_checks = 0, irq_cnt = 0, wipe_cnt = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) irq_cnt <= irq_cnt + int'(irq === 1'b1);
    always @(posedge aclk) wipe_cnt <= wipe_cnt + int'(wipe_volatile === 1'b1);
    fcs_sequencer #(.PAGES(256), .WORDS(32), .OP_CYCLES(8)) u_dut (.*);
    fcs_flash_master u_fm (.*);
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic timeout(input int n);
        if (n >= 60)
        begin
            check("wait bound", 32'h0000_0000, 32'h0000_0001);
            summarize();
        end
    endtask : timeout
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic aw, w, b;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 60; n++)
        begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            if (b) break;
        end
        s_bready <= 1'b0;
        timeout(n);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar, rv;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 60; n++)
        begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            rv = s_rvalid;
            d = s_rdata;
            r = s_rresp;
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
            if (rv) break;
        end
        s_rready <= 1'b0;
        timeout(n);
    endtask : axi_rd
    task automatic stat(input string nm, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] s;
        logic [1:0] r;
        axi_rd(FCS_OFF_STAT, s, r);
        check(nm, s & m, e);
    endtask : stat
    task automatic wait_idle();
        int n;
        repeat (2) @(posedge aclk);
        for (n = 0; n < 60 && f_stall !== 1'b0; n++) @(posedge aclk);
        timeout(n);
        repeat (2) @(posedge aclk);
    endtask : wait_idle
    function automatic logic [31:0] cw(input logic [7:0] k, input logic [7:0] p, input logic [5:0] c);
        return {k, 8'h00, p, 2'b00, c};
    endfunction : cw
    task automatic run(input logic [5:0] c, input logic [7:0] p, input logic [31:0] e);
        axi_wr(FCS_OFF_CMD, cw(FCS_KEY, p, c));
        wait_idle();
        stat("status", 32'h0000_000d, e);
    endtask : run
    task automatic fuse(input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(FCS_OFF_FUSE, d, r);
        check("fuses", d, e);
    endtask : fuse
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        stat("reset status", 32'h0000_000d, 32'h0000_0001);
        fuse(FCS_FUSE_RESET);
        axi_rd(12'h0f0, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, FCS_RESP_SLVERR});
    endtask : t_reset
    task automatic t_cmds();
        logic [5:0] cd [7] = '{FCS_CMD_CPB, FCS_CMD_WP, FCS_CMD_EP, FCS_CMD_LOCK,
            FCS_CMD_UNLOCK, FCS_CMD_QPR, FCS_CMD_QUICK_USER_PAGE_READ};
        int c0;
        axi_wr(FCS_OFF_CTRL, 32'h0000_0001);
        for (int i = 0; i < 7; i++)
        begin
            c0 = irq_cnt;
            axi_wr(FCS_OFF_CMD, cw(FCS_KEY, 8'h28, cd[i]));
            stat("ready low", 32'h0000_0001, 32'h0000_0000);
            wait_idle();
            stat("ready high", 32'h0000_000d, 32'h0000_0001);
            check("irq count", 32'(irq_cnt - c0), {31'h0, i < 5});
        end
    endtask : t_cmds
    task automatic t_program_error_flag(input logic [31:0] w1, input logic [31:0] w2);
        axi_wr(FCS_OFF_CMD, w1);
        if (w2 != 32'h0000_0000) axi_wr(FCS_OFF_CMD, w2);
        wait_idle();
        stat("prog error", 32'h0000_0008, 32'h0000_0008);
        stat("error cleared", 32'h0000_0008, 32'h0000_0000);
    endtask : t_program_error_flag
    task automatic t_lock();
        int c0;
        axi_wr(FCS_OFF_CTRL, 32'h0000_0004);
        run(FCS_CMD_LOCK, 8'd20, 32'h0000_0001);
        fuse(32'hffff_fffd);
        run(FCS_CMD_WP, 8'd17, 32'h0000_0005);
        c0 = irq_cnt;
        run(FCS_CMD_EA, 8'd0, 32'h0000_0005);
        check("lock irq", 32'(irq_cnt - c0), 32'h0000_0001);
        check("no wipe", 32'(wipe_cnt), 32'h0000_0000);
        run(FCS_CMD_UNLOCK, 8'd20, 32'h0000_0001);
        fuse(FCS_FUSE_RESET);
        axi_wr(FCS_OFF_SECURE, 32'h0000_0008);
        run(FCS_CMD_WP, 8'd48, 32'h0000_0005);
        run(FCS_CMD_EA, 8'd0, 32'h0000_0001);
        check("wipe", 32'(wipe_cnt), 32'h0000_0001);
        fuse(FCS_FUSE_RESET);
    endtask : t_lock
    task automatic t_pbuf();
        logic [31:0] d;
        logic [1:0] r;
        run(FCS_CMD_EP, 8'h28, 32'h0000_0001);
        run(FCS_CMD_CPB, 8'h00, 32'h0000_0001);
        wr <= 1'b1;
        @(posedge aclk);
        wr <= 1'b0;
        repeat (3) @(posedge aclk);
        axi_rd(FCS_OFF_CMD, d, r);
        check("page number", d, 32'h0000_2803);
        run(FCS_CMD_WP, 8'h28, 32'h0000_0001);
        run(FCS_CMD_QPR, 8'h28, 32'h0000_0001);
        stat("qpr zero", 32'h0000_0020, 32'h0000_0000);
        run(FCS_CMD_EP, 8'h28, 32'h0000_0001);
        run(FCS_CMD_QPR, 8'h28, 32'h0000_0001);
        stat("qpr ones", 32'h0000_0020, 32'h0000_0020);
    endtask : t_pbuf
    task automatic t_stall();
        int n;
        axi_wr(FCS_OFF_CMD, cw(FCS_KEY, 8'h28, FCS_CMD_EP));
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        for (n = 0; n < 60 && got !== 1'b1; n++) @(posedge aclk);
        timeout(n);
        check("stalled read done", {31'h0, got}, 32'h0000_0001);
    endtask : t_stall
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_cmds();
        t_pbuf();
        t_program_error_flag(cw(8'h00, 8'h28, FCS_CMD_EP), 32'h0000_0000);
        t_program_error_flag(cw(FCS_KEY, 8'h28, 6'h3f), 32'h0000_0000);
        t_program_error_flag(cw(FCS_KEY, 8'h28, FCS_CMD_EP), cw(FCS_KEY, 8'h28, FCS_CMD_EP));
        t_stall();
        t_lock();
        summarize();
    end
endmodule : flash_command_sequencer_tb
`default_nettype wire
